// ### ice_chain_node.sv
// Behaviour
// - Drive and sample reset; start after last release
// - Drive power-good/reset only if host or FPGA
// - Pass reset primary to secondary, never back
// - After link init, send buffer-release count
// - Reset base to zero; answer zero if first
// - Command write with byte lane 0 enabled sets host-direction bit
// - Base write assigns; stop answering zero
// - Drop-on-uninitialized control resets inactive
// - Firmware fetch aborts unless default bridge here
//
// Purpose: Per-device enumeration state of one chain node
// Assumes: Wishbone carries configuration accesses; link side reports status
// Notes: One clock; reset and link inputs are synchronised here
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module ice_chain_node #(
    parameter int BUF_COUNT_W = 8,
    parameter logic [7:0] BUF_COUNT = 8'h08,
    parameter logic CENTRAL_RESOURCE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ice_pkg::ice_wb_req_t wb_req_i,
    output ice_pkg::ice_wb_rsp_t wb_rsp_o,
    input wire logic cfg_link_i,
    input wire logic reset_pin_i,
    input wire logic power_good_signal_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    output logic power_good_signal_o,
    output logic power_good_signal_oe_o,
    output logic sec_reset_o,
    output logic sec_power_good_o,
    input wire logic link_init_done_i,
    input wire logic sw_reset_req_i,
    output logic buf_release_o,
    output logic [BUF_COUNT_W-1:0] buf_release_count_o,
    input wire logic buf_release_ready_i,
    output logic [ice_pkg::ICE_UNIT_W-1:0] base_unit_number_o,
    output logic respond_default_o,
    output logic end_of_chain_o,
    output logic transmitter_shutdown_o,
    output logic drop_uninit_o,
    input wire logic fw_fetch_i,
    output logic fw_fetch_done_o,
    output logic fw_fetch_abort_o
);
    import ice_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] pg_sync;
        logic [1:0] lnk_sync;
        ice_phase_t phase;
        logic [ICE_UNIT_W-1:0] base;
        logic assigned;
        logic host_dir;
        logic def_dir;
        logic eoc;
        logic transmitter_shutdown;
        logic drop;
        logic def_bridge;
        logic ack;
        logic [31:0] rdat;
        logic fw_done;
        logic fw_abort;
    } ice_state_t;

    ice_state_t s_q;
    ice_state_t s_d;
    logic bus_hit;
    logic is_default_addr;
    logic wr_cmd;
    logic reset_seen;
    logic [31:0] rd_mux;

    // Access accepted on every strobe outside the ack cycle; the assigned and unassigned terms together always match
    assign is_default_addr = !s_q.assigned;
    assign bus_hit = wb_req_i.cyc && wb_req_i.stb && !s_q.ack
        && (cfg_link_i || is_default_addr || s_q.assigned);
    assign wr_cmd = bus_hit && wb_req_i.we && wb_req_i.adr == ICE_CMD_OFS && wb_req_i.sel[0];
    // Sample the shared reset wire, so our own release never hides a late one
    assign reset_seen = !s_q.rst_sync[1] || s_q.phase == ICE_IN_RESET && sw_reset_req_i;

    // Read data selection
    always_comb begin
        rd_mux = ICE_UNMAPPED;
        unique case (wb_req_i.adr)
            ICE_CMD_OFS: begin
                rd_mux[ICE_CMD_HOSTDIR_BIT] = s_q.host_dir;
                rd_mux[ICE_CMD_DEFDIR_BIT] = s_q.def_dir;
            end
            ICE_BASE_OFS: rd_mux[ICE_UNIT_W-1:0] = s_q.base;
            ICE_LINK_OFS: begin
                rd_mux[ICE_LINK_EOC_BIT] = s_q.eoc;
                rd_mux[ICE_LINK_TRANSMITTER_SHUTDOWN_BIT] = s_q.transmitter_shutdown;
                rd_mux[ICE_LINK_DROP_BIT] = s_q.drop;
                rd_mux[ICE_LINK_DEFBR_BIT] = s_q.def_bridge;
            end
            ICE_STAT_OFS: begin
                rd_mux[ICE_STAT_ASSIGNED_BIT] = s_q.assigned;
                rd_mux[ICE_STAT_RESETIN_BIT] = !s_q.rst_sync[1];
                rd_mux[ICE_STAT_RELEASED_BIT] = s_q.phase != ICE_IN_RESET;
                rd_mux[ICE_STAT_LINKUP_BIT] = s_q.lnk_sync[1];
            end
            ICE_ID_OFS: rd_mux = ICE_ID_VALUE;
            default: rd_mux = ICE_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Two-stage synchronisers for pin level inputs
        s_d.rst_sync = {s_q.rst_sync[0], reset_pin_i};
        s_d.pg_sync = {s_q.pg_sync[0], power_good_signal_i};
        s_d.lnk_sync = {s_q.lnk_sync[0], link_init_done_i};
        s_d.ack = 1'b0;
        s_d.fw_done = 1'b0;
        s_d.fw_abort = 1'b0;
        // A link lost while credits are offered is left to the chain reset behind it
        // Phase sequence: wait for last reset release, link, then credits
        unique case (s_q.phase)
            ICE_IN_RESET: if (!reset_seen) s_d.phase = ICE_LINK_WAIT;
            ICE_LINK_WAIT: if (s_q.lnk_sync[1]) s_d.phase = ICE_CREDIT;
            ICE_CREDIT: if (buf_release_ready_i) s_d.phase = ICE_RUN;
            ICE_RUN: s_d.phase = ICE_RUN;
        endcase
        // Register accesses; one-cycle ack then a gap cycle
        if (bus_hit) begin
            s_d.ack = 1'b1;
            s_d.rdat = rd_mux;
            if (wb_req_i.we && wb_req_i.sel[0]) begin
                unique case (wb_req_i.adr)
                    ICE_CMD_OFS: s_d.def_dir = wb_req_i.dat[ICE_CMD_DEFDIR_BIT];
                    ICE_BASE_OFS: begin
                        s_d.base = wb_req_i.dat[ICE_UNIT_W-1:0];
                        s_d.assigned = 1'b1;
                    end
                    ICE_LINK_OFS: begin
                        s_d.eoc = wb_req_i.dat[ICE_LINK_EOC_BIT];
                        s_d.transmitter_shutdown = wb_req_i.dat[ICE_LINK_TRANSMITTER_SHUTDOWN_BIT];
                        s_d.drop = wb_req_i.dat[ICE_LINK_DROP_BIT];
                        s_d.def_bridge = wb_req_i.dat[ICE_LINK_DEFBR_BIT];
                    end
                    default: s_d.assigned = s_q.assigned;
                endcase
            end
        end
        // A command write with byte lane 0 enabled points host direction at the arrival link
        if (wr_cmd) s_d.host_dir = cfg_link_i;
        // Firmware fetch answered at once; abort when no default bridge here
        if (fw_fetch_i) begin
            s_d.fw_done = 1'b1;
            s_d.fw_abort = !s_q.def_bridge;
        end
        // Chain reset returns phase, base, assigned and drop to defaults
        if (reset_seen) begin
            s_d.phase = ICE_IN_RESET;
            s_d.base = ICE_DEFAULT_UNIT;
            s_d.assigned = 1'b0;
            s_d.drop = 1'b0;
        end
    end

    // Register the whole state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.phase <= ICE_IN_RESET;
            s_q.base <= ICE_DEFAULT_UNIT;
            s_q.drop <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = s_q.rdat;
    // Ordinary nodes never drive the shared wires; the wire is left to its pull-up
    assign reset_pin_oe_o = CENTRAL_RESOURCE && (rst_i || sw_reset_req_i);
    assign reset_pin_o = 1'b0;
    assign power_good_signal_oe_o = CENTRAL_RESOURCE && rst_i;
    assign power_good_signal_o = 1'b0;
    // Secondary side follows primary only; nothing flows back
    assign sec_reset_o = s_q.rst_sync[1];
    assign sec_power_good_o = s_q.pg_sync[1];
    assign buf_release_o = s_q.phase == ICE_CREDIT;
    assign buf_release_count_o = BUF_COUNT_W'(BUF_COUNT); // Sized to the count port
    assign base_unit_number_o = s_q.base;
    assign respond_default_o = !s_q.assigned;
    assign end_of_chain_o = s_q.eoc;
    assign transmitter_shutdown_o = s_q.transmitter_shutdown;
    assign drop_uninit_o = s_q.drop;
    assign fw_fetch_done_o = s_q.fw_done;
    assign fw_fetch_abort_o = s_q.fw_abort;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_base_default;
        @(posedge clk_i) disable iff (rst_i) !s_q.assigned |-> s_q.base == ICE_DEFAULT_UNIT;
    endproperty
    a_base_default: assert property (p_base_default) else $error("base not default");
    property p_host_dir;
        @(posedge clk_i) disable iff (rst_i) wr_cmd |=> s_q.host_dir == $past(cfg_link_i);
    endproperty
    a_host_dir: assert property (p_host_dir) else $error("host dir not set");
    property p_assign;
        @(posedge clk_i) disable iff (rst_i)
        bus_hit && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == ICE_BASE_OFS && !reset_seen
        |=> !respond_default_o;
    endproperty
    a_assign: assert property (p_assign) else $error("still answers default");
    // The written number lands whole; a reset in the same cycle wins instead
    property p_base_write;
        @(posedge clk_i) disable iff (rst_i)
        bus_hit && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == ICE_BASE_OFS && !reset_seen
        |=> base_unit_number_o == $past(wb_req_i.dat[ICE_UNIT_W-1:0]);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base not written");
    // A chain reset always leaves the node answering the default number
    property p_reset_default;
        @(posedge clk_i) disable iff (rst_i) reset_seen |=> respond_default_o
        && base_unit_number_o == ICE_DEFAULT_UNIT;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset kept base");
    // Lane 0 disabled: the access is answered but nothing changes
    property p_sel_ignore;
        @(posedge clk_i) disable iff (rst_i)
        bus_hit && wb_req_i.we && !wb_req_i.sel[0] && !reset_seen
        |=> $stable(s_q.base) && $stable(s_q.assigned) && $stable(s_q.eoc);
    endproperty
    a_sel_ignore: assert property (p_sel_ignore) else $error("masked write took effect");
    // Ack is a single-cycle pulse; a request still held in the gap cycle after it is taken again
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) wb_rsp_o.ack |=> !wb_rsp_o.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_no_drive;
        @(posedge clk_i) !CENTRAL_RESOURCE |-> !reset_pin_oe_o && !power_good_signal_oe_o;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("non-host drove reset");
    // Forwarded levels trail the primary pins by the two synchroniser stages
    property p_sec;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> sec_reset_o == $past(reset_pin_i, 2);
    endproperty
    a_sec: assert property (p_sec) else $error("secondary reset mismatch");
    property p_sec_pg;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> sec_power_good_o == $past(power_good_signal_i, 2);
    endproperty
    a_sec_pg: assert property (p_sec_pg) else $error("secondary power-good mismatch");
    property p_release;
        @(posedge clk_i) disable iff (rst_i) buf_release_o |-> s_q.lnk_sync[1] || $past(s_q.lnk_sync[1]);
    endproperty
    a_release: assert property (p_release) else $error("credits before link");
    // Once the taker is ready the announcement ends on the next edge
    property p_credit_done;
        @(posedge clk_i) disable iff (rst_i)
        buf_release_o && buf_release_ready_i |=> !buf_release_o;
    endproperty
    a_credit_done: assert property (p_credit_done) else $error("credits repeated");
    property p_reset_hold;
        @(posedge clk_i) disable iff (rst_i) reset_seen |=> s_q.phase == ICE_IN_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("left reset early");
    property p_drop;
        @(posedge clk_i) disable iff (rst_i) reset_seen |=> !drop_uninit_o;
    endproperty
    a_drop: assert property (p_drop) else $error("drop not cleared");
    property p_fw;
        @(posedge clk_i) disable iff (rst_i) fw_fetch_i |=> fw_fetch_done_o && fw_fetch_abort_o == !$past(s_q.def_bridge);
    endproperty
    a_fw: assert property (p_fw) else $error("fetch answer wrong");
    // No fetch, no answer: a stray done would read as the chain that owns the ROM
    property p_fw_idle;
        @(posedge clk_i) disable iff (rst_i)
        !fw_fetch_i |=> !fw_fetch_done_o && !fw_fetch_abort_o;
    endproperty
    a_fw_idle: assert property (p_fw_idle) else $error("unasked fetch answer");
    c_assign: cover property (@(posedge clk_i) s_q.assigned && !$past(s_q.assigned));
    c_credit: cover property (@(posedge clk_i) buf_release_o);
    c_abort: cover property (@(posedge clk_i) fw_fetch_abort_o);
    // A fetch answered cleanly, and a chain reset hitting an assigned node
    c_fetch_ok: cover property (@(posedge clk_i) fw_fetch_done_o && !fw_fetch_abort_o);
    c_rst_assigned: cover property (@(posedge clk_i) reset_seen && s_q.assigned);
endmodule // ice_chain_node

// ### ice_link_partner.sv
// Purpose: Far side of one node: reset initiator, link trainer and credit taker
// Assumes: Reset pin is open drain with pull-up; level resolved by the bench
// Notes: Credit ready answers on alternate cycles to stall the node
`timescale 1ns/100ps
module ice_link_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_reset_i,
    input wire logic reset_pin_i,
    input wire logic buf_release_i,
    output logic reset_oe_o,
    output logic power_good_o,
    output logic link_init_done_o,
    output logic buf_release_ready_o
);
    logic [3:0] train_q;
    // ------------------------------------------------------------
    // Reset drive and link training
    // ------------------------------------------------------------
    // Drive reset low while asked, but train only on the sampled wire level,
    // since another initiator may still hold the line
    assign reset_oe_o = rst_i | hold_reset_i;
    always_ff @(posedge clk_i) begin
        power_good_o <= ~rst_i;
        if (reset_pin_i == 1'b0) begin
            train_q <= 4'h0;
            link_init_done_o <= 1'b0;
        end else if (train_q != 4'hf) begin
            train_q <= train_q + 4'h1;
        end else begin
            link_init_done_o <= 1'b1;
        end
        // Slow taker of buffer-release credits
        buf_release_ready_o <= buf_release_i & ~buf_release_ready_o & train_q[0];
    end
endmodule // ice_link_partner

// ### ice_pkg.sv
// Purpose: Shared constants and carriers for the chain enumeration block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Register map offsets are word aligned
package ice_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ICE_CMD_OFS = 8'h00;
    localparam logic [7:0] ICE_BASE_OFS = 8'h04;
    localparam logic [7:0] ICE_LINK_OFS = 8'h08;
    localparam logic [7:0] ICE_STAT_OFS = 8'h0c;
    localparam logic [7:0] ICE_ID_OFS = 8'h10;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int ICE_UNIT_W = 5;
    localparam logic [4:0] ICE_DEFAULT_UNIT = 5'h00;
    localparam int ICE_CMD_HOSTDIR_BIT = 0;
    localparam int ICE_CMD_DEFDIR_BIT = 1;
    localparam int ICE_LINK_EOC_BIT = 0;
    localparam int ICE_LINK_TRANSMITTER_SHUTDOWN_BIT = 1;
    localparam int ICE_LINK_DROP_BIT = 2;
    localparam int ICE_LINK_DEFBR_BIT = 3;
    localparam int ICE_STAT_ASSIGNED_BIT = 0;
    localparam int ICE_STAT_RESETIN_BIT = 1;
    localparam int ICE_STAT_RELEASED_BIT = 2;
    localparam int ICE_STAT_LINKUP_BIT = 3;
    localparam logic [31:0] ICE_ID_VALUE = 32'h00c0ffee; // Arbitrary value
    localparam logic [31:0] ICE_UNMAPPED = 32'h00000000;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ice_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ice_wb_rsp_t;
    typedef enum logic [1:0] {ICE_IN_RESET, ICE_LINK_WAIT, ICE_CREDIT, ICE_RUN} ice_phase_t;
endpackage

// ### io_chain_enumeration_tb.sv
// Purpose: Self-checking bench for one chain node
// Assumes: Classic Wishbone single cycles; partner model on the link side
// Notes: Reset pin level is the wired-AND of all open-drain drivers
`timescale 1ns/100ps
module io_chain_enumeration_tb;
    import ice_pkg::*;
    logic clk_i, rst_i, cfg_link_i, sw_reset_req_i, fw_fetch_i, hold_rst;
    logic rst_oe, pg, lid, rdy, reset_pin_i;
    ice_wb_req_t req;
    ice_wb_rsp_t rsp;
    logic r_o, r_oe, pg_o, pg_oe, sec_r, sec_pg, br, resp_def, eoc, transmitter_shutdown, drop, done, abrt;
    logic [7:0] br_cnt;
    logic [4:0] base;
    logic [31:0] q;
    int n_fail, n_tests, n;
    // Host-side sizing bookkeeping
    logic [7:0] next_unassigned_unit_number, group_mask, final_group_mask;
    logic partial_grouping_flag, no_grouping_flag;
    always #4 clk_i = ~clk_i;
    // Open drain with pull-up: low if anyone enables a driver
    assign reset_pin_i = ~(rst_oe | r_oe);
    ice_link_partner ptn (.clk_i(clk_i), .rst_i(rst_i), .hold_reset_i(hold_rst),
        .reset_pin_i(reset_pin_i), .buf_release_i(br), .reset_oe_o(rst_oe),
        .power_good_o(pg), .link_init_done_o(lid), .buf_release_ready_o(rdy));
    ice_chain_node dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .cfg_link_i(cfg_link_i), .reset_pin_i(reset_pin_i), .power_good_signal_i(pg & ~pg_oe),
        .reset_pin_o(r_o), .reset_pin_oe_o(r_oe), .power_good_signal_o(pg_o),
        .power_good_signal_oe_o(pg_oe), .sec_reset_o(sec_r), .sec_power_good_o(sec_pg),
        .link_init_done_i(lid), .sw_reset_req_i(sw_reset_req_i), .buf_release_o(br),
        .buf_release_count_o(br_cnt), .buf_release_ready_i(rdy), .base_unit_number_o(base),
        .respond_default_o(resp_def), .end_of_chain_o(eoc), .transmitter_shutdown_o(transmitter_shutdown),
        .drop_uninit_o(drop), .fw_fetch_i(fw_fetch_i), .fw_fetch_done_o(done),
        .fw_fetch_abort_o(abrt));
    // ------------------------------------------------------------
    // Closing, compare and bus tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    // Hold the request until ack is sampled high, then release
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (rsp.ack !== 1'b1 && k < 50);
        q = rsp.dat;
        req <= '0;
        if (k >= 50) begin
            n_fail++;
            report_and_stop();
        end
        #1;
    endtask
    // Fetch pulse, then wait a bounded time for its answer
    task automatic fetch(input logic exp_abort);
        @(posedge clk_i);
        fw_fetch_i <= 1'b1;
        @(posedge clk_i);
        fw_fetch_i <= 1'b0;
        // Look off the edge so the one-cycle answer is seen while it stands
        #1;
        for (n = 0; n < 4 && done !== 1'b1; n++) #8;
        chk(done, 1'b1);
        chk(abrt, exp_abort);
        if (n >= 4) report_and_stop();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {clk_i, cfg_link_i, sw_reset_req_i, fw_fetch_i, hold_rst} = '0;
        rst_i = 1'b1;
        req = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        sw_reset_req_i <= 1'b1;
        @(posedge clk_i);
        #1 chk({r_oe, pg_oe, r_o, pg_o}, 4'h0);
        sw_reset_req_i <= 1'b0;
        for (n = 0; n < 200 && br !== 1'b1; n++) @(posedge clk_i);
        #1 chk(br_cnt, 8'h08);
        chk(br, 1'b1);
        if (n >= 200) report_and_stop();
        repeat (20) @(posedge clk_i);
        // The bench is the lone master host: no slave host waits or wakes
        next_unassigned_unit_number = 8'h01;
        group_mask = 8'h00;
        final_group_mask = 8'h00;
        wb(1'b0, ICE_STAT_OFS, 0, 4'hf);
        chk(q[ICE_STAT_RELEASED_BIT], 1'b1);
        chk(q[ICE_STAT_LINKUP_BIT], 1'b1);
        chk(q[ICE_STAT_RESETIN_BIT], 1'b0);
        wb(1'b0, ICE_BASE_OFS, 0, 4'hf);
        chk(q, 0);
        chk({resp_def, drop}, 2'b10);
        wb(1'b0, ICE_LINK_OFS, 0, 4'hf);
        chk(q[ICE_LINK_DROP_BIT], 1'b0);
        // A clean, open link: no end-of-chain or shutdown set yet
        chk(q, 0);
        cfg_link_i <= 1'b1;
        wb(1'b1, ICE_CMD_OFS, 0, 4'hf);
        wb(1'b0, ICE_CMD_OFS, 0, 4'hf);
        chk(q[1:0], 2'b01);
        cfg_link_i <= 1'b0;
        wb(1'b1, ICE_CMD_OFS, 32'h2, 4'hf);
        wb(1'b0, ICE_CMD_OFS, 0, 4'hf);
        chk(q[1:0], 2'b10);
        // No grouping block here, so group_mask takes no bits from this node;
        // flag it, then try the reorder-disable bit, which this node lacks
        partial_grouping_flag = 1'b1;
        wb(1'b1, 8'h20, 32'h1, 4'hf);
        wb(1'b0, 8'h20, 0, 4'hf);
        chk(q, ICE_UNMAPPED);
        no_grouping_flag = ~q[0];
        // Assign only while the node's one unit still fits below number 31
        if (next_unassigned_unit_number + 8'h01 <= 8'h1f) begin
            wb(1'b1, ICE_BASE_OFS, {24'h0, next_unassigned_unit_number}, 4'he);
            chk({base, resp_def}, 6'h01);
            wb(1'b1, ICE_BASE_OFS, {24'h0, next_unassigned_unit_number}, 4'hf);
            chk({base, resp_def}, {next_unassigned_unit_number[4:0], 1'b0});
            next_unassigned_unit_number = next_unassigned_unit_number + 8'h01;
        end
        fetch(1'b1);
        // Close the chain: end-of-chain first, shutdown once the link is ignored
        wb(1'b1, ICE_LINK_OFS, 32'h1, 4'hf);
        chk({eoc, transmitter_shutdown}, 2'b10);
        // Partitioning ends here; the node carries no master enable to set after it
        wb(1'b1, ICE_LINK_OFS, 32'hb, 4'hf);
        chk({eoc, transmitter_shutdown, drop}, 3'h6);
        fetch(1'b0);
        // Compatibility chain reached: now arm the drop-on-uninitialized control
        wb(1'b1, ICE_LINK_OFS, 32'hf, 4'hf);
        chk({eoc, transmitter_shutdown, drop}, 3'h7);
        // Host grouping needs both flags clear; this chain holds a node without it
        if (!partial_grouping_flag && !no_grouping_flag) begin
            final_group_mask = group_mask | 8'h0e;
        end
        chk(final_group_mask, 8'h00);
        wb(1'b0, ICE_ID_OFS, 0, 4'hf);
        chk(q, ICE_ID_VALUE);
        hold_rst <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk({sec_r, base, resp_def}, 7'h01);
        hold_rst <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk({sec_r, sec_pg}, 2'b11);
        report_and_stop();
    end
endmodule // io_chain_enumeration_tb
